//--- dv/rsg_arbiter_tb.sv
/*
  Self-checking bench for the group run/stop arbiter with one peer model.
  Assumes shortened ms, timeout and discovery parameters; one 100 MHz clock.
*/
module rsg_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsg_pkg::*;
  typedef struct packed {
    logic kr, ks;
    logic [1:0] cmd;
    logic ct, po, pr, ps, er;
    rsg_ind_type ei;
  } rsg_row_type;
  logic clk_i = 0, sys_rst_i = 1;
  logic [7:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o, d;
  logic reg_we_i = 0, reg_re_i = 0, key_run_i = 0, key_stop_i = 0, contact_input_i = 1, key_activity_i = 0;
  logic p_open = 0, p_run = 0, p_stop = 0, rx_valid_i, tx_valid_o, run_o, temp_rise_start_o, irq_o;
  rsg_peer_rec_type rx_rec_i, tx_rec_o;
  rsg_ind_type stop_ind_o;
  int bad_count = 0, checks_done = 0, rises = 0, txs = 0;
  rsg_row_type rows [12] = '{
    '{1,0,0,1,0,0,0,1,IND_NONE}, '{0,1,0,1,0,0,0,0,IND_KEY}, '{1,0,0,1,0,0,0,1,IND_NONE},
    '{0,0,0,0,0,0,0,0,IND_PLAIN}, '{1,0,0,0,0,0,0,0,IND_CONTACT}, '{0,0,0,1,0,0,0,1,IND_NONE},
    '{0,0,0,1,1,0,0,0,IND_GROUP}, '{0,0,0,1,0,1,0,1,IND_NONE}, '{0,0,0,1,0,0,1,0,IND_KEY},
    '{0,0,0,1,0,1,0,1,IND_NONE}, '{0,0,2'h2,1,0,0,0,0,IND_KEY}, '{0,0,2'h1,1,0,0,0,1,IND_NONE}};

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  rsg_arbiter #(.CYC_MS(2), .TMO_MS(20), .DISC_WIN_MS(40)) u_rsg_arbiter (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .key_run_i(key_run_i),
    .key_stop_i(key_stop_i), .key_activity_i(key_activity_i), .contact_input_i(contact_input_i),
    .peer_link_port_ok_i(1'b1), .rx_valid_i(rx_valid_i), .rx_rec_i(rx_rec_i), .tx_valid_o(tx_valid_o),
    .tx_rec_o(tx_rec_o), .run_o(run_o), .stop_ind_o(stop_ind_o), .temp_rise_start_o(temp_rise_start_o),
    .irq_o(irq_o));

  rsg_peer_model u_rsg_peer_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .group_i(5'h01), .run_req_i(p_run), .stop_req_i(p_stop),
    .contact_open_i(p_open), .valid_o(rx_valid_i), .rec_o(rx_rec_i));

  // pulse counters for the group run start and our own link sends
  always @(posedge clk_i) begin
    if (temp_rise_start_o === 1'b1) rises++;
    if (tx_valid_o === 1'b1 && tx_rec_o.group === 5'h01) txs++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  // three slots cover the slot sampling plus the peer send gap
  task automatic settle();
    repeat (420) @(posedge clk_i);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1 chk({run_o, irq_o, 1'b0, stop_ind_o}, {2'b00, 1'b0, IND_PLAIN});
    $display("reset test done");
    reg_wr(REG_IRQ_EN, 32'hf);
    reg_wr(REG_SET_NEW, 32'h0000_0601);
    reg_rd(REG_SET_NEW, d); chk(d, 32'h8000_0601);
    reg_wr(REG_SET_ACT, 32'h0);
    reg_rd(REG_SET_ACT, d); chk(d, 32'h0000_0601);
    reg_wr(REG_SET_NEW, 32'h0000_0611);
    reg_rd(REG_SET_NEW, d); chk(d, 32'h0000_0601);
    reg_wr(REG_SET_NEW, 32'h0000_0901);
    reg_rd(REG_SET_NEW, d); chk(d, 32'h0000_0601);
    reg_rd(8'h20, d); chk(d, 32'h0);
    $display("setting test done");
    // table rows: local keys, host command, own contact and peer events
    foreach (rows[i]) begin
      @(posedge clk_i);
      key_run_i <= rows[i].kr;
      key_stop_i <= rows[i].ks;
      contact_input_i <= rows[i].ct;
      p_open <= rows[i].po;
      p_run <= rows[i].pr;
      p_stop <= rows[i].ps;
      @(posedge clk_i);
      {key_run_i, key_stop_i, p_run, p_stop} <= 4'h0;
      if (rows[i].cmd != 2'h0) reg_wr(REG_CMD, {30'h0, rows[i].cmd});
      settle();
      chk({31'h0, run_o}, {31'h0, rows[i].er});
      chk({29'h0, stop_ind_o}, {29'h0, rows[i].ei});
      $display("row %0d done", i);
    end
    chk(rises, 6);
    chk({31'h0, txs > 0}, 32'h1);
    reg_rd(REG_STATE, d); chk(d, 32'h0000_0101);
    // uncommitted edit dropped after the shortened timeout
    reg_wr(REG_SET_NEW, 32'h0000_0602);
    // key activity restarts the timeout, so the edit outlives its first deadline
    repeat (30) @(posedge clk_i);
    key_activity_i <= 1'b1;
    @(posedge clk_i);
    key_activity_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    reg_rd(REG_SET_NEW, d); chk(d, 32'h8000_0602);
    repeat (30) @(posedge clk_i);
    reg_rd(REG_SET_ACT, d); chk(d, 32'h0000_0601);
    reg_rd(REG_IRQ_STAT, d); chk(d, 32'h7);
    chk({31'h0, irq_o}, 32'h1);
    reg_wr(REG_IRQ_CLR, 32'h7);
    reg_rd(REG_IRQ_STAT, d); chk(d, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    reg_wr(REG_IRQ_EN, 32'h0);
    $display("timeout and interrupt test done");
    // group 0 leaves group behaviour: peer stop must not reach us
    key_stop_i <= 1'b1;
    @(posedge clk_i);
    key_stop_i <= 1'b0;
    settle();
    reg_wr(REG_SET_NEW, 32'h0000_0600);
    reg_wr(REG_SET_ACT, 32'h0);
    key_run_i <= 1'b1;
    @(posedge clk_i);
    key_run_i <= 1'b0;
    settle();
    p_stop <= 1'b1;
    @(posedge clk_i);
    p_stop <= 1'b0;
    settle();
    chk({31'h0, run_o}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    $display("ungrouped test done");
    test_done();
  end
endmodule

//--- dv/rsg_peer_model.sv
/*
  Peer controller model on the shared link: sends one record every GAP cycles.
  Assumes the bench pulses run/stop requests and holds the contact level.
*/
module rsg_peer_model
  import rsg_pkg::*;
#(
  parameter logic [4:0] PEER_ADDR = 5'h01,
  parameter int GAP = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // requests from the bench
  input wire logic [4:0] group_i,
  input wire logic run_req_i,
  input wire logic stop_req_i,
  input wire logic contact_open_i,
  // link side
  output logic valid_o,
  output rsg_peer_rec_type rec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic run_p, stop_p;

  // latch events until the next send; a later event replaces an earlier one
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      run_p <= 1'b0;
      stop_p <= 1'b0;
      valid_o <= 1'b0;
      rec_o <= '0;
    end else if (cnt == GAP - 1) begin
      // a request on the send edge goes out with this record instead of being dropped
      cnt <= 0;
      valid_o <= 1'b1;
      rec_o <= '{PEER_ADDR, group_i, run_req_i || (run_p && !stop_req_i), stop_req_i || (stop_p && !run_req_i),
                 contact_open_i};
      run_p <= 1'b0;
      stop_p <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      valid_o <= 1'b0;
      rec_o <= ~rec_o; // released record never repeats the last value
      if (stop_req_i) begin
        stop_p <= 1'b1;
        run_p <= 1'b0;
      end else if (run_req_i) begin
        run_p <= 1'b1;
        stop_p <= 1'b0;
      end
    end
  end
endmodule

//--- inc/rsg_pkg.sv
/*
  Shared constants and carriers for the group run/stop arbiter: register map,
  field layouts, reset values, stop-cause codes and timing figures.
  Assumes a single 100 MHz system clock.
*/
package rsg_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_IN_NS = 1000000;
  localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  localparam int SLOT_MS = 70;
  localparam int TIMEOUT_S = 60;
  localparam int TIMEOUT_MS = TIMEOUT_S * 1000;
  localparam int MAX_PEERS = 32;
  localparam int DISC_MS = SLOT_MS * MAX_PEERS;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_SET_NEW = 8'h00;
  localparam logic [7:0] REG_SET_ACT = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN = 8'h18;
  localparam logic [7:0] REG_LINK_ADDR = 8'h1c;

  // field positions
  localparam int F_GROUP_LSB = 0;
  localparam int F_CT_LSB = 8;
  localparam int F_PEND_BIT = 31;
  localparam int F_CMD_RUN = 0;
  localparam int F_CMD_STOP = 1;
  localparam int F_ST_RUN = 0;
  localparam int F_ST_IND_LSB = 4;
  localparam int F_ST_CNT_LSB = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_RUN = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_REFUSE = 3;

  // setting ranges and codes
  localparam logic [4:0] GROUP_MAX = 5'h10;
  localparam logic [3:0] CT_MIN = 4'h1;
  localparam logic [3:0] CT_MAX = 4'h8;
  localparam logic [3:0] CT_RS_A = 4'h2;
  localparam logic [3:0] CT_RS_B = 4'h3;
  localparam logic [3:0] CT_RS_C = 4'h4;
  localparam logic [3:0] CT_RS_ONLY = 4'h6;

  // reset values
  localparam logic [4:0] RST_GROUP = 5'h00;
  localparam logic [3:0] RST_CT = 4'h1;
  localparam logic [4:0] RST_LINK_ADDR = 5'h00;

  // stop-cause indication codes
  typedef enum logic [2:0] {
    IND_NONE = 3'h0,
    IND_PLAIN = 3'h1,
    IND_KEY = 3'h2,
    IND_CONTACT = 3'h3,
    IND_GROUP = 3'h4
  } rsg_ind_type;

  typedef struct packed {
    logic [4:0] group;
    logic [3:0] ct_assign;
  } rsg_setting_type;

  // one record exchanged per link slot
  typedef struct packed {
    logic [4:0] addr;
    logic [4:0] group;
    logic run_evt;
    logic stop_evt;
    logic contact_stop;
  } rsg_peer_rec_type;

endpackage

//--- rtl/rsg_arbiter.sv
/*
  Group run/stop arbiter: resolves this controller's run or stop state from
  key, host and contact requests and from peer records on the peer link.
  Assumes peer records arrive already framed and that inputs are synchronous
  to clk_i; registers are reached over a plain strobe port.
*/
// Our own choices: the placing of the registers and the address-and-strobe port.
module rsg_arbiter
  import rsg_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS,
  parameter int TMO_MS = TIMEOUT_MS,
  parameter int DISC_WIN_MS = DISC_MS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // front panel and contact
  input wire logic key_run_i,
  input wire logic key_stop_i,
  input wire logic key_activity_i,
  input wire logic contact_input_i,
  // peer link
  input wire logic peer_link_port_ok_i,
  input wire logic rx_valid_i,
  input wire rsg_peer_rec_type rx_rec_i,
  output logic tx_valid_o,
  output rsg_peer_rec_type tx_rec_o,
  // controller outputs
  output logic run_o,
  output rsg_ind_type stop_ind_o,
  output logic temp_rise_start_o,
  output logic irq_o
);

  typedef enum logic {RS_STOP = 1'b0, RS_RUN = 1'b1} rsg_run_type;
  typedef enum logic {SET_IDLE = 1'b0, SET_EDIT = 1'b1} rsg_set_type;

  logic ms_tick;
  logic slot_tick;

  rsg_tick_div #(.CYC_MS(CYC_MS), .MS_SLOT(SLOT_MS)) u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ms_tick_o(ms_tick),
    .slot_tick_o(slot_tick)
  );

  // true for assignment codes whose contact carries run/stop
  function automatic logic ct_has_rs(input logic [3:0] code);
    ct_has_rs = (code == CT_RS_A) || (code == CT_RS_B) || (code == CT_RS_C) || (code == CT_RS_ONLY);
  endfunction

  function automatic logic [5:0] popcount(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h0;
    for (int i = 0; i < MAX_PEERS; i++) begin
      n = n + {5'h0, v[i]};
    end
    popcount = n;
  endfunction

  // state
  logic contact_s1, contact_s2, contact_d;
  rsg_setting_type cfg_act, cfg_new, next_cfg_act, next_cfg_new;
  rsg_set_type set_st, next_set_st;
  logic [15:0] tmo_cnt, next_tmo_cnt;
  logic [4:0] own_addr, next_own_addr;
  logic cmd_run, next_cmd_run;
  logic [31:0] peer_dstop, next_peer_dstop, known, next_known;
  logic [11:0] disc_cnt, next_disc_cnt;
  logic disc_done, next_disc_done;
  logic ev_run, ev_stop, next_ev_run, next_ev_stop;
  rsg_run_type run_st, next_run_st;
  rsg_ind_type next_ind;
  logic next_temp, next_tx_valid;
  rsg_peer_rec_type next_tx_rec;
  logic [IRQ_W-1:0] irq_stat, irq_en, next_irq_stat, next_irq_en, irq_set;
  logic [31:0] next_rdata;

  // decoded conditions
  logic grouped, ct_rs, loc_dstop, grp_dstop, close_edge, open_edge;
  logic wr_cmd, loc_run_evt, loc_stop_evt, rx_known, rx_ok, commit_ok, refuse_set;
  logic [4:0] new_group;
  logic [3:0] new_ct;

  assign new_group = reg_wdata_i[F_GROUP_LSB +: 5];
  assign new_ct = reg_wdata_i[F_CT_LSB +: 4];
  assign grouped = peer_link_port_ok_i && (cfg_act.group != RST_GROUP);
  assign ct_rs = ct_has_rs(cfg_act.ct_assign);
  assign loc_dstop = ct_rs && !contact_s2;
  assign grp_dstop = grouped && (|peer_dstop);
  assign close_edge = ct_rs && contact_s2 && !contact_d;
  assign open_edge = ct_rs && !contact_s2 && contact_d;
  assign wr_cmd = reg_we_i && (reg_addr_i == REG_CMD);
  assign loc_run_evt = key_run_i || (wr_cmd && reg_wdata_i[F_CMD_RUN]) || close_edge;
  assign loc_stop_evt = key_stop_i || (wr_cmd && reg_wdata_i[F_CMD_STOP]) || open_edge;
  assign rx_known = !disc_done || known[rx_rec_i.addr];
  assign rx_ok = rx_valid_i && rx_known && grouped && (rx_rec_i.group == cfg_act.group) && (rx_rec_i.addr != own_addr);
  // a change of assignment or group is only taken while stopped
  assign commit_ok = reg_we_i && (reg_addr_i == REG_SET_ACT) && (set_st == SET_EDIT) && (run_st == RS_STOP);

  // contact synchroniser; the second stage and its one-cycle delayed copy (for edges) feed the logic
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      contact_s1 <= 1'b0;
      contact_s2 <= 1'b0;
      contact_d <= 1'b0;
    end else begin
      contact_s1 <= contact_input_i;
      contact_s2 <= contact_s1;
      contact_d <= contact_s2;
    end
  end

  // settings: edit, commit or drop on inactivity
  always_comb begin
    next_cfg_act = cfg_act;
    next_cfg_new = cfg_new;
    next_set_st = set_st;
    next_tmo_cnt = tmo_cnt;
    next_own_addr = own_addr;
    irq_set = '0;
    if (key_activity_i) begin
      next_tmo_cnt = 16'h0;
    end else if (set_st == SET_EDIT && ms_tick) begin
      next_tmo_cnt = tmo_cnt + 16'h1;
      if (tmo_cnt == 16'(TMO_MS - 1)) begin
        next_set_st = SET_IDLE;
        irq_set[IRQ_DROP] = 1'b1;
      end
    end
    if (reg_we_i && reg_addr_i == REG_SET_NEW && new_group <= GROUP_MAX && new_ct >= CT_MIN && new_ct <= CT_MAX) begin
      next_cfg_new = '{group: new_group, ct_assign: new_ct};
      next_set_st = SET_EDIT;
      next_tmo_cnt = 16'h0;
    end else if (commit_ok) begin
      next_cfg_act = cfg_new;
      next_set_st = SET_IDLE;
    end
    if (reg_we_i && reg_addr_i == REG_LINK_ADDR) begin
      next_own_addr = reg_wdata_i[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_act <= '{group: RST_GROUP, ct_assign: RST_CT};
      cfg_new <= '{group: RST_GROUP, ct_assign: RST_CT};
      set_st <= SET_IDLE;
      tmo_cnt <= 16'h0;
      own_addr <= RST_LINK_ADDR;
    end else begin
      cfg_act <= next_cfg_act;
      cfg_new <= next_cfg_new;
      set_st <= next_set_st;
      tmo_cnt <= next_tmo_cnt;
      own_addr <= next_own_addr;
    end
  end

  // group command, peer contact stops, discovery and outgoing events
  always_comb begin
    next_cmd_run = cmd_run;
    next_peer_dstop = peer_dstop;
    next_known = known;
    next_disc_cnt = disc_cnt;
    next_disc_done = disc_done;
    next_ev_run = ev_run;
    next_ev_stop = ev_stop;
    refuse_set = 1'b0;
    // stop from any source has priority over run in the same cycle
    if (loc_stop_evt || (rx_ok && rx_rec_i.stop_evt)) begin
      next_cmd_run = 1'b0;
    end else if (loc_run_evt || (rx_ok && rx_rec_i.run_evt)) begin
      next_cmd_run = 1'b1;
    end
    if (!disc_done && ms_tick) begin
      next_disc_cnt = disc_cnt + 12'h1;
      next_disc_done = (disc_cnt == 12'(DISC_WIN_MS - 1));
    end
    // only addresses heard during the power-up window count as members
    if (rx_valid_i && !disc_done) begin
      next_known[rx_rec_i.addr] = 1'b1;
    end
    if (rx_ok) begin
      next_peer_dstop[rx_rec_i.addr] = rx_rec_i.contact_stop;
    end else if (rx_valid_i && rx_rec_i.group != cfg_act.group) begin
      next_peer_dstop[rx_rec_i.addr] = 1'b0;
    end
    if (!grouped || commit_ok) begin
      next_peer_dstop = '0;
    end
    if (rx_valid_i && disc_done && !known[rx_rec_i.addr]) begin
      refuse_set = 1'b1;
    end
    // pending events are sent on the next slot; a newer one replaces an older
    if (slot_tick) begin
      next_ev_run = 1'b0;
      next_ev_stop = 1'b0;
    end
    if (loc_stop_evt) begin
      next_ev_stop = 1'b1;
      next_ev_run = 1'b0;
    end else if (loc_run_evt) begin
      next_ev_run = 1'b1;
      next_ev_stop = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_run <= 1'b0;
      peer_dstop <= 32'h0;
      known <= 32'h0;
      disc_cnt <= 12'h0;
      disc_done <= 1'b0;
      ev_run <= 1'b0;
      ev_stop <= 1'b0;
    end else begin
      cmd_run <= next_cmd_run;
      peer_dstop <= next_peer_dstop;
      known <= next_known;
      disc_cnt <= next_disc_cnt;
      disc_done <= next_disc_done;
      ev_run <= next_ev_run;
      ev_stop <= next_ev_stop;
    end
  end

  // resolved state and cause, taken once per link slot
  always_comb begin
    next_run_st = run_st;
    next_ind = stop_ind_o;
    next_temp = 1'b0;
    next_tx_valid = 1'b0;
    next_tx_rec = tx_rec_o;
    if (slot_tick) begin
      if (cmd_run && !loc_dstop && !grp_dstop) begin
        next_run_st = RS_RUN;
        next_ind = IND_NONE;
        next_temp = grouped && (run_st == RS_STOP);
      end else begin
        next_run_st = RS_STOP;
        if (!cmd_run) begin
          next_ind = (ct_rs && contact_s2) ? IND_KEY : IND_PLAIN;
        end else if (loc_dstop) begin
          next_ind = IND_CONTACT;
        end else begin
          next_ind = IND_GROUP;
        end
      end
      if (grouped) begin
        next_tx_valid = 1'b1;
        next_tx_rec = '{addr: own_addr, group: cfg_act.group, run_evt: ev_run, stop_evt: ev_stop,
                        contact_stop: loc_dstop};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_st <= RS_STOP;
      run_o <= 1'b0;
      stop_ind_o <= IND_PLAIN;
      temp_rise_start_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_rec_o <= '0;
    end else begin
      run_st <= next_run_st;
      run_o <= (next_run_st == RS_RUN);
      stop_ind_o <= next_ind;
      temp_rise_start_o <= next_temp;
      tx_valid_o <= next_tx_valid;
      tx_rec_o <= next_tx_rec;
    end
  end

  // interrupt status, enable and register reads; a set beats a clear
  always_comb begin
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    next_rdata = 32'h0;
    if (reg_we_i && reg_addr_i == REG_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~reg_wdata_i[IRQ_W-1:0];
    end
    if (reg_we_i && reg_addr_i == REG_IRQ_EN) begin
      next_irq_en = reg_wdata_i[IRQ_W-1:0];
    end
    next_irq_stat[IRQ_RUN] = next_irq_stat[IRQ_RUN] | (next_run_st == RS_RUN && run_st == RS_STOP);
    next_irq_stat[IRQ_STOP] = next_irq_stat[IRQ_STOP] | (next_run_st == RS_STOP && run_st == RS_RUN);
    next_irq_stat[IRQ_DROP] = next_irq_stat[IRQ_DROP] | irq_set[IRQ_DROP];
    next_irq_stat[IRQ_REFUSE] = next_irq_stat[IRQ_REFUSE] | refuse_set;
    if (reg_re_i) begin
      case (reg_addr_i)
        REG_SET_NEW: begin
          next_rdata[F_GROUP_LSB +: 5] = cfg_new.group;
          next_rdata[F_CT_LSB +: 4] = cfg_new.ct_assign;
          next_rdata[F_PEND_BIT] = (set_st == SET_EDIT);
        end
        REG_SET_ACT: begin
          next_rdata[F_GROUP_LSB +: 5] = cfg_act.group;
          next_rdata[F_CT_LSB +: 4] = cfg_act.ct_assign;
        end
        REG_STATE: begin
          next_rdata[F_ST_RUN] = run_o;
          next_rdata[F_ST_IND_LSB +: 3] = stop_ind_o;
          next_rdata[F_ST_CNT_LSB +: 6] = popcount(known);
        end
        REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
        REG_IRQ_EN: next_rdata[IRQ_W-1:0] = irq_en;
        REG_LINK_ADDR: next_rdata[4:0] = own_addr;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_stat <= '0;
      irq_en <= '0;
      irq_o <= 1'b0;
      reg_rdata_o <= 32'h0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      irq_o <= |(next_irq_stat & next_irq_en);
      reg_rdata_o <= next_rdata;
    end
  end

  // checks
  sequence s_last_ms;
    set_st == SET_EDIT && tmo_cnt == 16'(TMO_MS - 1) && ms_tick && !key_activity_i;
  endsequence
  sequence s_no_new_edit;
    !(reg_we_i && reg_addr_i == REG_SET_NEW);
  endsequence

  key_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    loc_stop_evt |=> !cmd_run) else $error("stop request did not clear the group command");
  peer_run_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rx_ok && rx_rec_i.run_evt && !rx_rec_i.stop_evt && !loc_stop_evt) |=> cmd_run)
    else $error("peer run event was lost");
  stop_prio_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (slot_tick && loc_dstop) |=> !run_o && stop_ind_o != IND_NONE) else $error("ran against a contact stop");
  group_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (slot_tick && cmd_run && !loc_dstop && grp_dstop) |=> !run_o && stop_ind_o == IND_GROUP)
    else $error("group contact stop not shown");
  ungrouped_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !grouped |=> peer_dstop == 32'h0 && !tx_valid_o) else $error("ungrouped controller kept peer state");
  drop_setting_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (s_last_ms ##0 s_no_new_edit) |=> set_st == SET_IDLE && irq_stat[IRQ_DROP])
    else $error("stale setting not dropped");
  temp_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    temp_rise_start_o |-> run_o && !$past(run_o)) else $error("temperature rise start without run edge");
  slot_update_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(run_o) |-> $past(slot_tick)) else $error("run state changed outside a link slot");
  late_peer_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rx_valid_i && disc_done && !known[rx_rec_i.addr]) |=> irq_stat[IRQ_REFUSE] && !$changed(known))
    else $error("undiscovered peer accepted");
  locked_cfg_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (run_st == RS_RUN) |=> $stable(cfg_act)) else $error("setting committed while running");

endmodule

//--- rtl/rsg_tick_div.sv
/*
  Rate divider: one-cycle enables for each millisecond and each link slot.
  Assumes one system clock and a synchronous active-high reset.
*/
module rsg_tick_div
  import rsg_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS,
  parameter int MS_SLOT = SLOT_MS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // enables
  output logic ms_tick_o,
  output logic slot_tick_o
);

  logic [31:0] cyc_cnt;
  logic [31:0] next_cyc_cnt;
  logic [15:0] ms_cnt;
  logic [15:0] next_ms_cnt;
  logic next_ms_tick;
  logic next_slot_tick;

  // cycle and millisecond counters wrap on their own end values
  always_comb begin
    next_ms_tick = 1'b0;
    next_slot_tick = 1'b0;
    next_cyc_cnt = cyc_cnt + 32'h1;
    next_ms_cnt = ms_cnt;
    if (cyc_cnt == 32'(CYC_MS - 1)) begin
      next_cyc_cnt = 32'h0;
      next_ms_tick = 1'b1;
      next_ms_cnt = ms_cnt + 16'h1;
      if (ms_cnt == 16'(MS_SLOT - 1)) begin
        next_ms_cnt = 16'h0;
        next_slot_tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cyc_cnt <= 32'h0;
      ms_cnt <= 16'h0;
      ms_tick_o <= 1'b0;
      slot_tick_o <= 1'b0;
    end else begin
      cyc_cnt <= next_cyc_cnt;
      ms_cnt <= next_ms_cnt;
      ms_tick_o <= next_ms_tick;
      slot_tick_o <= next_slot_tick;
    end
  end

endmodule
